// ### src/opmc_mode_ctrl.sv
/*
 Operating mode controller: run, active debug and wait modes.
 Assumes a CPU core that reports instruction events as one-cycle pulses,
 a debug serial engine that presents decoded commands, and a pin pad.
*/
// Functional notes
// [RQ1] Pin high at reset exit: run mode
// [RQ2] Run start fetches vector at FFFE:FFFF
// [RQ3] Pin low at reset exit: debug mode
// [RQ4] Halt command enters debug mode
// [RQ5] Enter-debug instruction enters debug mode
// [RQ6] Either breakpoint source enters debug mode
// [RQ7] Debug mode suspends user execution
// [RQ8] Non-intrusive commands accepted in run, debug
// [RQ9] Active-debug commands only in debug mode
// [RQ10] Trace runs one instruction, back to debug
// [RQ11] Resume leaves debug, continues user code
// [RQ12] Wait instruction gates the processor clock
// [RQ13] Wait keeps system clock, regulation on
// [RQ14] Wait entry clears interrupt mask bit
// [RQ15] Interrupt ends wait, starts stacking
// [RQ16] Wait accepts only halt, status-memory commands
// [RQ17] Status-memory in wait: no access, report
// [RQ18] Halt in wait goes to debug
// [RQ19] Shared pin defaults to mode/debug function
// [RQ20] Pin sampled once at reset release
`timescale 1ns/1ps
`default_nettype none
`include "opmc_params.svh"
module opmc_mode_ctrl
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Shared pin pad
   input wire logic mode_select_debug_pin_in,
   output logic pin_mux_debug_sel,
   // CPU events
   input wire logic enter_debug_instruction,
   input wire logic wait_instruction,
   input wire logic instr_done,
   input wire logic irq_request,
   // Breakpoint sources
   input wire logic ctrl_breakpoint_hit,
   input wire logic onchip_breakpoint_hit,
   // Debug command port
   input wire opmc_pkg::opmc_dbg_req_type dbg_req,
   output opmc_pkg::opmc_dbg_rsp_type dbg_rsp,
   // Core control
   output logic cpu_run_en,
   output logic cpu_clk_en,
   output logic sys_clk_en,
   output logic regulator_full,
   output logic vector_fetch,
   output logic [`OPMC_ADDR_W-1:0] vector_addr,
   output logic clear_int_mask,
   output logic irq_stacking,
   output logic in_debug,
   output logic in_wait
);
   typedef enum logic [5:0]
   {
      ST_RESET = 6'b000001,
      ST_VECTOR = 6'b000010,
      ST_RUN = 6'b000100,
      ST_DEBUG = 6'b001000,
      ST_TRACE = 6'b010000,
      ST_WAIT = 6'b100000
   } opmc_state_type;

   opmc_state_type state_reg;
   opmc_state_type state_next;
   logic pin_sync;
   logic vec_half_reg;
   logic vec_half_next;
   logic clr_mask_reg;
   logic stack_reg;
   logic fetch_reg;
   logic [`OPMC_ADDR_W-1:0] vaddr_reg;
   logic [`OPMC_ADDR_W-1:0] vaddr_next;
   opmc_pkg::opmc_dbg_rsp_type rsp_reg;
   opmc_pkg::opmc_dbg_rsp_type rsp_next;

   opmc_sync3 #(
      .RESET_VALUE(1'b1)
   )
   u_pin_sync
   (
      .core_clk(core_clk),
      .reset(reset),
      .async_in(mode_select_debug_pin_in),
      .sync_out(pin_sync)
   );

   // Command classes
   wire cmd_valid = dbg_req.valid;
   wire cmd_halt = cmd_valid && (dbg_req.cmd == opmc_pkg::OPMC_CMD_HALT);
   wire cmd_mstat = cmd_valid && (dbg_req.cmd == opmc_pkg::OPMC_CMD_MEM_STAT);
   wire cmd_nonintr = cmd_valid && (dbg_req.cmd == opmc_pkg::OPMC_CMD_MEM
      || dbg_req.cmd == opmc_pkg::OPMC_CMD_MEM_STAT
      || dbg_req.cmd == opmc_pkg::OPMC_CMD_CTRL_REG
      || dbg_req.cmd == opmc_pkg::OPMC_CMD_HALT);
   wire cmd_active = cmd_valid && (dbg_req.cmd == opmc_pkg::OPMC_CMD_CPU_REG
      || dbg_req.cmd == opmc_pkg::OPMC_CMD_TRACE
      || dbg_req.cmd == opmc_pkg::OPMC_CMD_RESUME);
   wire st_run = (state_reg == ST_RUN);
   wire st_dbg = (state_reg == ST_DEBUG);
   wire st_wait = (state_reg == ST_WAIT);
   wire bkpt_hit = ctrl_breakpoint_hit || onchip_breakpoint_hit; // RQ6
   wire go_debug_run = (cmd_halt || enter_debug_instruction || bkpt_hit); // RQ4 RQ5 RQ6
   wire accept_run = st_run && cmd_nonintr; // RQ8
   wire accept_dbg = st_dbg && (cmd_nonintr || cmd_active); // RQ8 RQ9
   wire accept_wait = st_wait && (cmd_halt || cmd_mstat); // RQ16
   wire accept_any = accept_run || accept_dbg || accept_wait;

   always_comb
   begin
      state_next = state_reg;
      vec_half_next = 1'b0;
      vaddr_next = vaddr_reg;
      case (state_reg)
         ST_RESET:
         begin
            if (pin_sync) // RQ20
            begin
               state_next = ST_VECTOR; // RQ1
               vaddr_next = `OPMC_VEC_HI_ADDR; // RQ2
            end
            else
            begin
               state_next = ST_DEBUG; // RQ3
            end
         end
         ST_VECTOR:
         begin
            if (!vec_half_reg)
            begin
               vec_half_next = 1'b1;
               vaddr_next = `OPMC_VEC_LO_ADDR; // RQ2
            end
            else
            begin
               state_next = ST_RUN;
            end
         end
         ST_RUN:
         begin
            if (go_debug_run)
            begin
               state_next = ST_DEBUG;
            end
            else if (wait_instruction)
            begin
               state_next = ST_WAIT; // RQ12
            end
         end
         ST_DEBUG:
         begin
            if (cmd_valid && dbg_req.cmd == opmc_pkg::OPMC_CMD_TRACE)
            begin
               state_next = ST_TRACE; // RQ10
            end
            else if (cmd_valid && dbg_req.cmd == opmc_pkg::OPMC_CMD_RESUME)
            begin
               state_next = ST_RUN; // RQ11
            end
         end
         ST_TRACE:
         begin
            if (instr_done)
            begin
               state_next = ST_DEBUG; // RQ10
            end
         end
         ST_WAIT:
         begin
            if (cmd_halt)
            begin
               state_next = ST_DEBUG; // RQ18
            end
            else if (irq_request)
            begin
               state_next = ST_RUN; // RQ15
            end
         end
         default:
         begin
            state_next = ST_RESET;
         end
      endcase
   end

   // Response to accepted or refused commands
   always_comb
   begin
      rsp_next = '0;
      if (cmd_valid)
      begin
         rsp_next.accept = accept_any;
         rsp_next.do_access = accept_any && !st_wait; // RQ17
         if (accept_wait && cmd_mstat)
         begin
            rsp_next.status = `OPMC_STAT_STOP_WAIT; // RQ17
         end
         else if (!accept_any)
         begin
            rsp_next.status = `OPMC_STAT_ILLEGAL; // RQ9 RQ16
         end
         else
         begin
            rsp_next.status = `OPMC_STAT_OK;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         state_reg <= ST_RESET;
         vec_half_reg <= 1'b0;
         vaddr_reg <= '0;
         rsp_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         vec_half_reg <= vec_half_next;
         vaddr_reg <= vaddr_next;
         rsp_reg <= rsp_next;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         clr_mask_reg <= 1'b0;
         stack_reg <= 1'b0;
         fetch_reg <= 1'b0;
      end
      else
      begin
         clr_mask_reg <= st_run && !go_debug_run && wait_instruction; // RQ14
         stack_reg <= st_wait && !cmd_halt && irq_request; // RQ15
         fetch_reg <= (state_next == ST_VECTOR); // RQ2
      end
   end

   assign pin_mux_debug_sel = 1'b1; // RQ19
   assign cpu_run_en = st_run || (state_reg == ST_TRACE); // RQ7
   assign cpu_clk_en = !st_wait; // RQ12
   assign sys_clk_en = 1'b1; // RQ13
   assign regulator_full = 1'b1; // RQ13
   assign vector_fetch = fetch_reg;
   assign vector_addr = vaddr_reg;
   assign clear_int_mask = clr_mask_reg;
   assign irq_stacking = stack_reg;
   assign in_debug = st_dbg || (state_reg == ST_TRACE);
   assign in_wait = st_wait;
   assign dbg_rsp = rsp_reg;

   property p_pin_low_debug;
      @(posedge core_clk) disable iff (reset)
      (state_reg == ST_RESET && !pin_sync) |=> (state_reg == ST_DEBUG);
   endproperty
   a_pin_low_debug: assert property (p_pin_low_debug) else $error("pin low no debug"); // RQ3

   property p_pin_high_vector;
      @(posedge core_clk) disable iff (reset)
      (state_reg == ST_RESET && pin_sync) |=> vector_fetch ##1 (vector_fetch
         && vector_addr == `OPMC_VEC_LO_ADDR) ##1 st_run;
   endproperty
   a_pin_high_vector: assert property (p_pin_high_vector) else $error("bad vector fetch"); // RQ1

   property p_bkpt_debug;
      @(posedge core_clk) disable iff (reset)
      (st_run && bkpt_hit) |=> st_dbg;
   endproperty
   a_bkpt_debug: assert property (p_bkpt_debug) else $error("breakpoint missed"); // RQ6

   property p_debug_suspend;
      @(posedge core_clk) disable iff (reset)
      st_dbg |-> !cpu_run_en;
   endproperty
   a_debug_suspend: assert property (p_debug_suspend) else $error("cpu runs in debug"); // RQ7

   property p_active_refused_run;
      @(posedge core_clk) disable iff (reset)
      (st_run && cmd_active) |=> (!dbg_rsp.accept && dbg_rsp.status == `OPMC_STAT_ILLEGAL);
   endproperty
   a_active_refused_run: assert property (p_active_refused_run) else $error("active cmd in run"); // RQ9

   property p_trace_one;
      @(posedge core_clk) disable iff (reset)
      (state_reg == ST_TRACE && instr_done) |=> st_dbg && !cpu_run_en;
   endproperty
   a_trace_one: assert property (p_trace_one) else $error("trace not one"); // RQ10

   property p_wait_mask;
      @(posedge core_clk) disable iff (reset)
      (st_run && !go_debug_run && wait_instruction) |=> clear_int_mask && in_wait && !cpu_clk_en;
   endproperty
   a_wait_mask: assert property (p_wait_mask) else $error("wait entry wrong"); // RQ14

   property p_wait_irq;
      @(posedge core_clk) disable iff (reset)
      (st_wait && irq_request && !cmd_halt) |=> st_run && irq_stacking;
   endproperty
   a_wait_irq: assert property (p_wait_irq) else $error("irq wake failed"); // RQ15

   property p_wait_status;
      @(posedge core_clk) disable iff (reset)
      (st_wait && cmd_mstat) |=> (dbg_rsp.accept && !dbg_rsp.do_access
         && dbg_rsp.status == `OPMC_STAT_STOP_WAIT);
   endproperty
   a_wait_status: assert property (p_wait_status) else $error("wait status wrong"); // RQ17

   property p_wait_halt;
      @(posedge core_clk) disable iff (reset)
      (st_wait && cmd_halt) |=> st_dbg;
   endproperty
   a_wait_halt: assert property (p_wait_halt) else $error("halt in wait failed"); // RQ18

   property p_halt_run;
      @(posedge core_clk) disable iff (reset)
      (st_run && cmd_halt) |=> (st_dbg && dbg_rsp.accept);
   endproperty
   a_halt_run: assert property (p_halt_run) else $error("halt in run failed"); // RQ4

   property p_nonintr_run;
      @(posedge core_clk) disable iff (reset)
      (st_run && cmd_nonintr) |=> (dbg_rsp.accept && dbg_rsp.status == `OPMC_STAT_OK);
   endproperty
   a_nonintr_run: assert property (p_nonintr_run) else $error("run cmd refused"); // RQ8

   property p_resume_dbg;
      @(posedge core_clk) disable iff (reset)
      (st_dbg && cmd_valid && dbg_req.cmd == opmc_pkg::OPMC_CMD_RESUME) |=> (st_run
         && cpu_run_en);
   endproperty
   a_resume_dbg: assert property (p_resume_dbg) else $error("resume failed"); // RQ11

   property p_wait_refuse;
      @(posedge core_clk) disable iff (reset)
      (st_wait && cmd_valid && !cmd_halt && !cmd_mstat) |=> (!dbg_rsp.accept
         && dbg_rsp.status == `OPMC_STAT_ILLEGAL);
   endproperty
   a_wait_refuse: assert property (p_wait_refuse) else $error("wait cmd accepted"); // RQ16
endmodule : opmc_mode_ctrl
`default_nettype wire

// ### src/opmc_params.svh
/*
 Address, width and code constants for the operating mode controller.
 Assumes inclusion by bare name from the package and design modules.
*/
`ifndef OPMC_PARAMS_SVH
`define OPMC_PARAMS_SVH
`define OPMC_VEC_HI_ADDR 16'hFFFE
`define OPMC_VEC_LO_ADDR 16'hFFFF
`define OPMC_ADDR_W 16
`define OPMC_STAT_OK 2'h0
`define OPMC_STAT_STOP_WAIT 2'h1
`define OPMC_STAT_ILLEGAL 2'h2
`define OPMC_CMD_W 3
`endif

// ### src/opmc_pkg.sv
/*
 Types shared by the operating mode controller.
 Assumes the params header is reachable on the include path.
*/
`include "opmc_params.svh"
package opmc_pkg;
   typedef enum logic [2:0]
   {
      OPMC_CMD_NONE = 3'h0,
      OPMC_CMD_MEM = 3'h1,
      OPMC_CMD_MEM_STAT = 3'h2,
      OPMC_CMD_CTRL_REG = 3'h3,
      OPMC_CMD_HALT = 3'h4,
      OPMC_CMD_CPU_REG = 3'h5,
      OPMC_CMD_TRACE = 3'h6,
      OPMC_CMD_RESUME = 3'h7
   } opmc_cmd_type;
   typedef struct packed
   {
      logic valid;
      opmc_cmd_type cmd;
   } opmc_dbg_req_type;
   typedef struct packed
   {
      logic accept;
      logic do_access;
      logic [1:0] status;
   } opmc_dbg_rsp_type;
endpackage : opmc_pkg

// ### src/opmc_sync3.sv
/*
 Three flip-flop input synchroniser with agreement filter.
 Assumes a single clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module opmc_sync3 #(
   parameter logic RESET_VALUE = 1'b1
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Pin side
   input wire logic async_in,
   // Core side
   output logic sync_out
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic out_reg;
   logic out_next;
   assign out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
   // Chain keeps sampling through reset so the level held at release is seen
   always_ff @(posedge core_clk)
   begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         out_reg <= (s2_reg == s3_reg) ? s3_reg : RESET_VALUE;
      end
      else
      begin
         out_reg <= out_next;
      end
   end
   assign sync_out = out_reg;
endmodule : opmc_sync3
`default_nettype wire

// ### tb/opmc_host_model.sv
/*
 Debug host model: drives the mode/debug pin and issues decoded commands.
 Assumes it launches requests on falling edges of core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module opmc_host_model
(
   // Clock
   input wire logic core_clk,
   // Device side
   output logic mode_select_debug_pin_in,
   output opmc_pkg::opmc_dbg_req_type dbg_req,
   input wire opmc_pkg::opmc_dbg_rsp_type dbg_rsp
);
   initial
   begin
      // Held high and stable across reset release, so run mode is chosen
      mode_select_debug_pin_in = 1'b1;
      dbg_req = '0;
   end

   // Level held on the pin across the next reset release
   task automatic hold_pin(input logic level);
      @(negedge core_clk);
      mode_select_debug_pin_in = level;
   endtask : hold_pin

   // One request per call; the answer is taken in the cycle after the edge
   task automatic send(input opmc_pkg::opmc_cmd_type cmd,
                       output opmc_pkg::opmc_dbg_rsp_type rsp);
      @(negedge core_clk);
      dbg_req.valid = 1'b1;
      dbg_req.cmd = cmd;
      @(negedge core_clk);
      rsp = dbg_rsp;
      dbg_req.valid = 1'b0;
      // Idle command field shows a different code, never the stale one
      dbg_req.cmd = opmc_pkg::opmc_cmd_type'(~cmd);
   endtask : send
endmodule : opmc_host_model
`default_nettype wire

// ### tb/tb.sv
/*
 Self-checking bench for the operating mode controller.
 Assumes the package, the params header and the host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "opmc_params.svh"
module tb;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [5:0] ev = '0;
   logic pin;
   opmc_pkg::opmc_dbg_req_type req;
   opmc_pkg::opmc_dbg_rsp_type rsp;
   opmc_pkg::opmc_dbg_rsp_type got;
   logic pmux, run_en, cclk, sclk, rfull, vf, cim, stk, dbg, wt;
   logic [`OPMC_ADDR_W-1:0] vaddr;
   int n_fail = 0;
   int comparisons = 0;
   int cyc = 0;
   int mode = 0;
   logic [31:0] seed = 32'hD7E21A15;
   opmc_pkg::opmc_cmd_type tbl [6] = '{opmc_pkg::OPMC_CMD_MEM, opmc_pkg::OPMC_CMD_MEM_STAT,
      opmc_pkg::OPMC_CMD_CTRL_REG, opmc_pkg::OPMC_CMD_CPU_REG, opmc_pkg::OPMC_CMD_TRACE,
      opmc_pkg::OPMC_CMD_RESUME};

   always #2.5 core_clk = ~core_clk;

   opmc_host_model host (.core_clk(core_clk), .mode_select_debug_pin_in(pin),
      .dbg_req(req), .dbg_rsp(rsp));

   opmc_mode_ctrl dut (.core_clk(core_clk), .reset(reset), .mode_select_debug_pin_in(pin),
      .pin_mux_debug_sel(pmux), .enter_debug_instruction(ev[0]), .ctrl_breakpoint_hit(ev[1]),
      .onchip_breakpoint_hit(ev[2]), .wait_instruction(ev[3]), .irq_request(ev[4]),
      .instr_done(ev[5]), .dbg_req(req), .dbg_rsp(rsp), .cpu_run_en(run_en),
      .cpu_clk_en(cclk), .sys_clk_en(sclk), .regulator_full(rfull), .vector_fetch(vf),
      .vector_addr(vaddr), .clear_int_mask(cim), .irq_stacking(stk), .in_debug(dbg),
      .in_wait(wt));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   task automatic summarize();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : summarize

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask : chk

   // One-cycle CPU event pulse, settled outputs checked afterwards
   task automatic cpu_ev(input int k);
      @(negedge core_clk);
      ev = 6'h01 << k;
      @(negedge core_clk);
      ev = '0;
   endtask : cpu_ev

   task automatic do_reset();
      @(negedge core_clk);
      reset = 1'b1;
      ev = '0;
      repeat (6) @(negedge core_clk);
      reset = 1'b0;
      for (int i = 0; i < 10 && vf !== 1'b1; i++) @(negedge core_clk);
      chk(vaddr, 16'hFFFE, "vector high byte");
      @(negedge core_clk);
      chk(vf, 1'b1, "vector second fetch");
      chk(vaddr, 16'hFFFF, "vector low byte");
      for (int i = 0; i < 5 && run_en !== 1'b1; i++) @(negedge core_clk);
      chk({run_en, dbg, wt}, 3'h4, "run mode after reset");
      mode = 0;
   endtask : do_reset

   // Reference model of command acceptance per mode
   task automatic cmd_chk(input opmc_pkg::opmc_cmd_type c);
      int n;
      logic acc;
      logic [1:0] st;
      n = int'(c);
      acc = (mode == 1) || (mode == 0 && n <= 4) || (mode == 2 && (n == 4 || n == 2));
      st = acc ? ((mode == 2 && n == 2) ? 2'h1 : 2'h0) : 2'h2;
      host.send(c, got);
      chk(got.accept, acc, "command accept");
      chk(got.status, st, "command status");
      if (n <= 3)
         chk(got.do_access, acc && mode != 2, "memory access");
      if (n == 4)
         mode = 1;
      if (n == 7 && mode == 1)
         mode = 0;
      chk({dbg, wt}, {mode == 1, mode == 2}, "mode after command");
   endtask : cmd_chk

   task automatic rand_cmds(input int n);
      repeat (n)
      begin
         seed = lfsr(seed);
         cmd_chk(tbl[seed % ((mode == 1) ? 4 : 6)]);
      end
   endtask : rand_cmds

   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_fail++;
         summarize();
      end
   end

   initial
   begin
      do_reset();
      chk(pmux, 1'b1, "pin mux function");
      rand_cmds(10);
      cmd_chk(opmc_pkg::OPMC_CMD_HALT);
      chk(run_en, 1'b0, "suspended in debug");
      rand_cmds(10);
      cmd_chk(opmc_pkg::OPMC_CMD_TRACE);
      chk(run_en, 1'b1, "trace runs");
      cpu_ev(5);
      chk({run_en, dbg}, 2'h1, "trace back to debug");
      cmd_chk(opmc_pkg::OPMC_CMD_RESUME);
      chk(run_en, 1'b1, "resumed");
      for (int k = 0; k < 3; k++)
      begin
         cpu_ev(k);
         chk({run_en, dbg}, 2'h1, "debug entry source");
         mode = 1;
         cmd_chk(opmc_pkg::OPMC_CMD_RESUME);
      end
      cpu_ev(3);
      chk({cim, wt, cclk, run_en}, 4'hC, "wait entry");
      chk({sclk, rfull}, 2'h3, "wait keeps clocks");
      mode = 2;
      rand_cmds(10);
      cpu_ev(4);
      chk({stk, wt, cclk, run_en}, 4'hB, "interrupt wake");
      mode = 0;
      cpu_ev(3);
      mode = 2;
      cmd_chk(opmc_pkg::OPMC_CMD_HALT);
      chk({cclk, run_en}, 2'h2, "halt wakes to debug");
      do_reset();
      host.hold_pin(1'b0);
      @(negedge core_clk);
      reset = 1'b1;
      repeat (6) @(negedge core_clk);
      reset = 1'b0;
      @(negedge core_clk);
      chk({run_en, dbg, vf}, 3'h2, "debug at reset exit");
      mode = 1;
      host.hold_pin(1'b1);
      cmd_chk(opmc_pkg::OPMC_CMD_RESUME);
      chk(run_en, 1'b1, "resumed after debug reset");
      summarize();
   end
endmodule : tb
`default_nettype wire
